// [pkg/sosc_pkg.sv]
// Purpose: Shared constants and types of the oscillator start and output configuration block
// Assumes: Byte-wide register port driven by the serial control port front end
// Notes:   Offsets are register byte addresses on that port
package sosc_pkg;

  // ==========================================================================
  // Register offsets
  localparam logic [7:0] ADDR_DEVICE_CONTROL    = 8'h0A;
  localparam logic [7:0] ADDR_XMO_HIGH   = 8'h10;
  localparam logic [7:0] ADDR_XMO_LOW    = 8'h11;
  localparam logic [7:0] ADDR_DRV_CTL    = 8'h15;
  localparam logic [7:0] ADDR_ODIV_HIGH  = 8'h16;
  localparam logic [7:0] ADDR_SOFT_RESET = 8'h48;

  // ==========================================================================
  // Field positions and widths
  localparam int BIT_SYNTH_PDN  = 6;
  localparam int BIT_CAL_TRIG   = 1;
  localparam int BIT_AUTO_START = 0;
  localparam int BIT_DIFF_PD    = 7;
  localparam int BIT_ODIV_MSB   = 0;
  localparam int BIT_SOFT_RESET = 0;
  localparam int XMO_WIDTH      = 10;

  // ==========================================================================
  // Reset values and write masks
  localparam logic [7:0] RST_DEVICE_CONTROL   = 8'h01;
  localparam logic [7:0] RST_DRV_CTL   = 8'h02;
  localparam logic [7:0] RST_ODIV_HIGH = 8'h00;
  localparam logic [7:0] MASK_DEVICE_CONTROL  = 8'h7F;
  localparam logic [7:0] MASK_DRV_CTL  = 8'h83;
  localparam logic [7:0] MASK_ODIV_HI  = 8'h01;
  localparam logic [9:0] RST_XMO       = 10'h000;

  // ==========================================================================
  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int CONFIG_NS     = 80;
  localparam int CONFIG_CYC    = (CONFIG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] CONFIG_LAST = 4'(CONFIG_CYC - 1);

  // ==========================================================================
  // Types
  typedef enum logic [1:0] {
    DRV_TRISTATE,
    DRV_LVPECL,
    DRV_LVDS,
    DRV_HCSL
  } sosc_drv_t;

  typedef enum {
    ST_CONFIG,
    ST_HALT,
    ST_CAL,
    ST_LOCK,
    ST_RUN,
    ST_PDN
  } sosc_state_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sosc_req_t;

  typedef struct packed {
    logic       synth_enable;
    logic       cal_reset;
    logic       cal_start;
    logic       outputs_enable;
  } sosc_pll_t;

endpackage : sosc_pkg

// [logic/sosc_dev_reset.sv]
// Purpose: Merges the device reset sources into one registered reset signal
// Assumes: Reset pin sampled synchronously to clk
// Notes:   Pin held low keeps the device in reset
`timescale 1ns/1ps
module sosc_dev_reset (
  // Clock and reset
  input  wire logic clk,
  input  wire logic srst,
  // Sources
  input  wire logic external_reset_pin_n,
  input  wire logic software_reset_bit,
  // Result
  output logic      dev_rst_ff
);

  logic nxt_dev_rst;

  // ==========================================================================
  // Source merge
  always_comb
  begin
    nxt_dev_rst = !external_reset_pin_n || software_reset_bit; // R05
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      dev_rst_ff <= 1'b1;
    end
    else
    begin
      dev_rst_ff <= nxt_dev_rst;
    end
  end

endmodule : sosc_dev_reset

// [logic/sosc_cfg.sv]
// Behaviour
// R01: Synth power-down set disables the PLL and holds calibration in reset; clearing restarts it.
// R02: Writing 1 to the calibration trigger starts a calibration and the bit clears when it ends.
// R03: After power-up or software reset the auto start bit decides, not the calibration trigger.
// R04: With auto start at 1 a device reset leads on its own to lock and enabled outputs.
// R05: Power-on reset, the external reset pin or the software reset bit all reset the device.
// R06: With auto start at 0 the device halts after configuration until the host sets the bit; here a calibration trigger write also ends the halt.
// R07: Writing 1 to the differential power-down bit powers down the output buffer.
// R08: The driver select field picks tri-state, LVPECL, LVDS or HCSL.
// R09: The output divider is 9 bits, its top bit at bit 0 of the divider high register.
// R10: The host programs the divider only with 5 to 511; 0 to 4 are reserved.
// R11: A 10-bit crystal margining offset sits in two registers and is not host writable.
// R12: The host keeps reserved fields intact by read-modify-write.
//
// Purpose: Start-up sequencer and output configuration registers
// Assumes: Byte register port from the serial control front end; analog status synchronous
// Notes:   Divider range is not policed; reserved values pass through unchanged
`timescale 1ns/1ps
module sosc_cfg (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              srst,
  // Device reset sources
  input  wire logic              external_reset_pin_n,
  // Register port
  input  wire sosc_pkg::sosc_req_t req,
  output logic [7:0]             rdata_ff,
  output logic                   rvalid_ff,
  // Analog status
  input  wire logic              cal_done,
  input  wire logic              pll_lock,
  // Analog controls
  output sosc_pkg::sosc_pll_t    pll_ff,
  output logic                   diff_buffer_power_down_ff,
  output sosc_pkg::sosc_drv_t    drv_mode_ff,
  output logic                   out_div_msb_ff
);

  // ==========================================================================
  // Declarations
  sosc_pkg::sosc_state_t state_ff, nxt_state;
  logic [3:0]            cnt_ff, nxt_cnt;
  logic [7:0]            devctl_ff, nxt_devctl;
  logic [7:0]            drvctl_ff, nxt_drvctl;
  logic [7:0]            odivh_ff, nxt_odivh;
  logic [9:0]            xtal_margin_offset_ff;
  logic [7:0]            nxt_rdata;
  sosc_pkg::sosc_pll_t   nxt_pll;
  logic                  nxt_dpd;
  sosc_pkg::sosc_drv_t   nxt_drv;
  logic                  dev_rst;
  logic                  sw_rst;
  logic                  wr_dev, wr_drv, wr_odiv;
  logic                  synth_power_down, auto_lock_start, calibration_trigger;
  logic                  trig_set;

  assign wr_dev  = req.wr && (req.addr == sosc_pkg::ADDR_DEVICE_CONTROL);
  assign wr_drv  = req.wr && (req.addr == sosc_pkg::ADDR_DRV_CTL);
  assign wr_odiv = req.wr && (req.addr == sosc_pkg::ADDR_ODIV_HIGH);
  assign sw_rst  = req.wr && (req.addr == sosc_pkg::ADDR_SOFT_RESET)
                   && req.wdata[sosc_pkg::BIT_SOFT_RESET];
  assign synth_power_down    = devctl_ff[sosc_pkg::BIT_SYNTH_PDN];
  assign auto_lock_start     = devctl_ff[sosc_pkg::BIT_AUTO_START];
  assign calibration_trigger = devctl_ff[sosc_pkg::BIT_CAL_TRIG];
  // Trigger ignored while configuring so auto start governs start-up
  assign trig_set = wr_dev && req.wdata[sosc_pkg::BIT_CAL_TRIG]
                    && (state_ff != sosc_pkg::ST_CONFIG); // R03

  sosc_dev_reset u_dev_reset (
    .clk                  (clk),
    .srst                 (srst),
    .external_reset_pin_n (external_reset_pin_n),
    .software_reset_bit   (sw_rst),
    .dev_rst_ff           (dev_rst)
  );

  // ==========================================================================
  // Registers
  always_comb
  begin
    nxt_devctl = devctl_ff;
    nxt_drvctl = drvctl_ff;
    nxt_odivh  = odivh_ff;
    if (wr_dev)
    begin
      nxt_devctl = req.wdata & sosc_pkg::MASK_DEVICE_CONTROL;
      nxt_devctl[sosc_pkg::BIT_CAL_TRIG] = calibration_trigger;
    end
    if (state_ff == sosc_pkg::ST_CAL && cal_done)
    begin
      nxt_devctl[sosc_pkg::BIT_CAL_TRIG] = 1'b0; // R02
    end
    if (trig_set)
    begin
      nxt_devctl[sosc_pkg::BIT_CAL_TRIG] = 1'b1; // R02
    end
    if (wr_drv)
    begin
      nxt_drvctl = req.wdata & sosc_pkg::MASK_DRV_CTL; // R07 R08
    end
    if (wr_odiv)
    begin
      nxt_odivh = req.wdata & sosc_pkg::MASK_ODIV_HI; // R09
    end
    unique case (req.addr)
      sosc_pkg::ADDR_DEVICE_CONTROL:   nxt_rdata = devctl_ff;
      sosc_pkg::ADDR_XMO_HIGH:  nxt_rdata = {6'h00, xtal_margin_offset_ff[9:8]}; // R11
      sosc_pkg::ADDR_XMO_LOW:   nxt_rdata = xtal_margin_offset_ff[7:0]; // R11
      sosc_pkg::ADDR_DRV_CTL:   nxt_rdata = drvctl_ff;
      sosc_pkg::ADDR_ODIV_HIGH: nxt_rdata = odivh_ff;
      default:                  nxt_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (srst || dev_rst)
    begin
      devctl_ff <= sosc_pkg::RST_DEVICE_CONTROL; // R05
      drvctl_ff <= sosc_pkg::RST_DRV_CTL;
      odivh_ff  <= sosc_pkg::RST_ODIV_HIGH;
      xtal_margin_offset_ff <= sosc_pkg::RST_XMO; // R11
    end
    else
    begin
      devctl_ff <= nxt_devctl;
      drvctl_ff <= nxt_drvctl;
      odivh_ff  <= nxt_odivh;
    end
    if (srst)
    begin
      rdata_ff  <= 8'h00;
      rvalid_ff <= 1'b0;
    end
    else
    begin
      rdata_ff  <= req.rd ? nxt_rdata : rdata_ff;
      rvalid_ff <= req.rd;
    end
  end

  // ==========================================================================
  // Start-up sequencer
  always_comb
  begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    unique case (state_ff)
      sosc_pkg::ST_CONFIG:
      begin
        nxt_cnt = cnt_ff + 4'h1;
        if (cnt_ff == sosc_pkg::CONFIG_LAST)
        begin
          nxt_state = auto_lock_start ? sosc_pkg::ST_CAL : sosc_pkg::ST_HALT; // R03 R04 R06
        end
      end
      sosc_pkg::ST_HALT:
      begin
        if ((wr_dev && req.wdata[sosc_pkg::BIT_AUTO_START]) || trig_set)
        begin
          nxt_state = sosc_pkg::ST_CAL; // R06 R02
        end
      end
      sosc_pkg::ST_CAL:
      begin
        if (cal_done)
        begin
          nxt_state = sosc_pkg::ST_LOCK;
        end
      end
      sosc_pkg::ST_LOCK:
      begin
        if (pll_lock)
        begin
          nxt_state = sosc_pkg::ST_RUN; // R04
        end
      end
      sosc_pkg::ST_RUN:
      begin
        // A trigger that landed during lock is still pending here
        if (trig_set || calibration_trigger)
        begin
          nxt_state = sosc_pkg::ST_CAL; // R02
        end
      end
      sosc_pkg::ST_PDN:
      begin
        if (!synth_power_down)
        begin
          nxt_state = sosc_pkg::ST_CAL; // R01
        end
      end
    endcase
    // Caught at the end of configuration too, so no calibration starts
    if (synth_power_down
        && (state_ff != sosc_pkg::ST_CONFIG || cnt_ff == sosc_pkg::CONFIG_LAST))
    begin
      nxt_state = sosc_pkg::ST_PDN; // R01
    end
    if (dev_rst)
    begin
      nxt_state = sosc_pkg::ST_CONFIG; // R05
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst || dev_rst)
    begin
      state_ff <= sosc_pkg::ST_CONFIG; // R05
      cnt_ff   <= 4'h0;
    end
    else
    begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
    end
  end

  // ==========================================================================
  // Analog controls
  always_comb
  begin
    nxt_pll.synth_enable   = (nxt_state != sosc_pkg::ST_PDN); // R01
    nxt_pll.cal_reset      = (nxt_state == sosc_pkg::ST_PDN)
                             || (nxt_state == sosc_pkg::ST_CONFIG); // R01
    nxt_pll.cal_start      = (nxt_state == sosc_pkg::ST_CAL) && (state_ff != sosc_pkg::ST_CAL);
    nxt_pll.outputs_enable = (nxt_state == sosc_pkg::ST_RUN); // R04
    nxt_dpd = dev_rst ? sosc_pkg::RST_DRV_CTL[sosc_pkg::BIT_DIFF_PD]
                      : nxt_drvctl[sosc_pkg::BIT_DIFF_PD]; // R07
    nxt_drv = sosc_pkg::sosc_drv_t'(dev_rst ? sosc_pkg::RST_DRV_CTL[1:0]
                                            : nxt_drvctl[1:0]); // R08
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      pll_ff                    <= '0;
      diff_buffer_power_down_ff <= 1'b0;
      drv_mode_ff               <= sosc_pkg::DRV_LVDS;
      out_div_msb_ff            <= 1'b0;
    end
    else
    begin
      pll_ff                    <= nxt_pll;
      diff_buffer_power_down_ff <= nxt_dpd;
      drv_mode_ff               <= nxt_drv;
      out_div_msb_ff            <= dev_rst ? 1'b0 : nxt_odivh[sosc_pkg::BIT_ODIV_MSB]; // R09
    end
  end

  // ==========================================================================
  // Checks
  chk_pdn_disables: assert property (@(posedge clk) disable iff (srst || dev_rst) // R01
    synth_power_down && state_ff != sosc_pkg::ST_CONFIG |=> !pll_ff.synth_enable
      && pll_ff.cal_reset)
    else $error("power-down did not disable synth");
  chk_pdn_restart: assert property (@(posedge clk) disable iff (srst || dev_rst) // R01
    state_ff == sosc_pkg::ST_PDN && !synth_power_down |=> state_ff == sosc_pkg::ST_CAL)
    else $error("calibration not restarted after power-down");
  chk_trig_clears: assert property (@(posedge clk) disable iff (srst || dev_rst) // R02
    state_ff == sosc_pkg::ST_CAL && cal_done && !trig_set |=> !calibration_trigger)
    else $error("calibration trigger did not self-clear");
  chk_trig_starts: assert property (@(posedge clk) disable iff (srst || dev_rst) // R02
    trig_set && state_ff == sosc_pkg::ST_RUN && !synth_power_down
      |=> state_ff == sosc_pkg::ST_CAL ##0 pll_ff.cal_start)
    else $error("trigger did not start calibration");
  chk_cfg_auto: assert property (@(posedge clk) disable iff (srst || dev_rst) // R03
    state_ff == sosc_pkg::ST_CONFIG && cnt_ff == sosc_pkg::CONFIG_LAST && !synth_power_down
      |=> state_ff == ($past(auto_lock_start) ? sosc_pkg::ST_CAL : sosc_pkg::ST_HALT))
    else $error("start-up path ignored auto start");
  chk_lock_outputs: assert property (@(posedge clk) disable iff (srst || dev_rst) // R04
    state_ff == sosc_pkg::ST_LOCK && pll_lock && !synth_power_down |=> pll_ff.outputs_enable)
    else $error("outputs not enabled after lock");
  chk_dev_reset: assert property (@(posedge clk) disable iff (srst) // R05
    !external_reset_pin_n |=> ##1 state_ff == sosc_pkg::ST_CONFIG
      && devctl_ff == sosc_pkg::RST_DEVICE_CONTROL)
    else $error("reset pin did not reset device");
  chk_halt_holds: assert property (@(posedge clk) disable iff (srst || dev_rst) // R06
    state_ff == sosc_pkg::ST_HALT && !wr_dev |=> state_ff == sosc_pkg::ST_HALT
      || state_ff == sosc_pkg::ST_PDN)
    else $error("left halt without host write");
  chk_drv_follow: assert property (@(posedge clk) disable iff (srst || dev_rst) // R07 R08
    wr_drv |=> diff_buffer_power_down_ff == $past(req.wdata[7])
      && drv_mode_ff == sosc_pkg::sosc_drv_t'($past(req.wdata[1:0])))
    else $error("driver control not applied");
  chk_xmo_fixed: assert property (@(posedge clk) disable iff (srst || dev_rst) // R11
    req.rd && req.addr == sosc_pkg::ADDR_XMO_LOW |=> rdata_ff == sosc_pkg::RST_XMO[7:0])
    else $error("margin offset read back wrong");

endmodule : sosc_cfg

// [dv/sosc_pll_model.sv]
// Purpose: Behavioural model of the synthesizer analog side
// Assumes: Calibration start is a one-cycle pulse
// Notes:   Delay input lets the bench pick a prompt or a slow calibration
`timescale 1ns/1ps
module sosc_pll_model (
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                srst,
  // Controls from the block
  input  wire sosc_pkg::sosc_pll_t pll,
  input  wire logic [7:0]          cal_delay,
  // Status to the block
  output logic                     cal_done,
  output logic                     pll_lock
);
  logic [7:0] cnt;
  logic       busy;

  initial
  begin
    cal_done = 1'b0;
    pll_lock = 1'b0;
    busy     = 1'b0;
    cnt      = 8'h00;
  end

  // ==========================================================================
  // Calibration then lock; lock is lost whenever the loop is reset
  always @(posedge clk)
  begin
    cal_done <= 1'b0;
    if (srst || pll.cal_reset || !pll.synth_enable)
    begin
      busy     <= 1'b0;
      pll_lock <= 1'b0;
    end
    else if (pll.cal_start)
    begin
      busy     <= 1'b1;
      cnt      <= cal_delay;
      pll_lock <= 1'b0;
    end
    else if (busy && cnt == 8'h00)
    begin
      busy     <= 1'b0;
      cal_done <= 1'b1;
    end
    else if (busy)
      cnt <= cnt - 8'h01;
    else if (cal_done)
      pll_lock <= 1'b1;
  end
endmodule : sosc_pll_model

// [dv/testbench.sv]
// Purpose: Self-checking bench of the start-up and output configuration block
// Assumes: Inputs change at the falling edge; one register access at a time
// Notes:   Reserved bits are written as zero, as a careful host would
`timescale 1ns/1ps
module testbench;
  logic                clk       = 1'b0;
  logic                srst      = 1'b1;
  logic                pin_n     = 1'b1;
  sosc_pkg::sosc_req_t req       = '0;
  logic [7:0]          cal_delay = 8'h02;
  logic [7:0]          rdata_ff;
  logic                rvalid_ff;
  logic                cal_done;
  logic                pll_lock;
  sosc_pkg::sosc_pll_t pll_ff;
  logic                dpd_ff;
  sosc_pkg::sosc_drv_t drv_mode_ff;
  logic                msb_ff;
  logic [1:0]          m;
  int                  bad_count = 0;
  int                  checks    = 0;

  always #5 clk = ~clk;

  sosc_cfg u_dut (
    .clk                       (clk),
    .srst                      (srst),
    .external_reset_pin_n      (pin_n),
    .req                       (req),
    .rdata_ff                  (rdata_ff),
    .rvalid_ff                 (rvalid_ff),
    .cal_done                  (cal_done),
    .pll_lock                  (pll_lock),
    .pll_ff                    (pll_ff),
    .diff_buffer_power_down_ff (dpd_ff),
    .drv_mode_ff               (drv_mode_ff),
    .out_div_msb_ff            (msb_ff)
  );

  sosc_pll_model u_pll (
    .clk       (clk),
    .srst      (srst),
    .pll       (pll_ff),
    .cal_delay (cal_delay),
    .cal_done  (cal_done),
    .pll_lock  (pll_lock)
  );

  // ==========================================================================
  // Access and compare tasks
  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp)
    begin
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
      bad_count++;
    end
  endtask : check

  task automatic reg_wr(input logic [7:0] addr, input logic [7:0] data);
    @(negedge clk);
    req.wr    = 1'b1;
    req.addr  = addr;
    req.wdata = data;
    @(negedge clk);
    req.wr = 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [7:0] addr, input logic [7:0] exp, input string name);
    @(negedge clk);
    req.rd   = 1'b1;
    req.addr = addr;
    @(negedge clk);
    req.rd = 1'b0;
    check("read valid", 8'h01, {7'h00, rvalid_ff});
    check(name, exp, rdata_ff);
  endtask : reg_rd

  // Bounded wait; a miss shows up as a mismatch
  task automatic wait_oe(input logic v, input int lim);
    int n;
    n = 0;
    while (pll_ff.outputs_enable !== v && n < lim)
    begin
      @(negedge clk);
      n++;
    end
    check("outputs enable", {7'h00, v}, {7'h00, pll_ff.outputs_enable});
  endtask : wait_oe

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : print_verdict

  // ==========================================================================
  // Tests
  initial
  begin
    repeat (8) @(negedge clk);
    srst = 1'b0;
    reg_rd(sosc_pkg::ADDR_DEVICE_CONTROL, 8'h01, "device control");
    reg_rd(sosc_pkg::ADDR_DRV_CTL, 8'h02, "driver control");
    reg_rd(sosc_pkg::ADDR_ODIV_HIGH, 8'h00, "divider high");
    reg_rd(sosc_pkg::ADDR_XMO_HIGH, 8'h00, "margin high");
    reg_rd(8'h30, 8'h00, "unmapped");
    check("driver mode", 8'h02, {6'h00, drv_mode_ff});
    wait_oe(1'b1, 100);
    check("synth enable", 8'h01, {7'h00, pll_ff.synth_enable});
    $display("test reset and autostart done");
    for (int i = 0; i < 4; i++)
    begin
      m = 2'(i);
      reg_wr(sosc_pkg::ADDR_DRV_CTL, {m[0], 5'h00, m});
      check("driver mode", {6'h00, m}, {6'h00, drv_mode_ff});
      check("buffer down", {7'h00, m[0]}, {7'h00, dpd_ff});
      reg_rd(sosc_pkg::ADDR_DRV_CTL, {m[0], 5'h00, m}, "drv");
    end
    reg_wr(sosc_pkg::ADDR_ODIV_HIGH, 8'h01);
    check("divider msb", 8'h01, {7'h00, msb_ff});
    reg_rd(sosc_pkg::ADDR_ODIV_HIGH, 8'h01, "divider high");
    reg_wr(sosc_pkg::ADDR_XMO_HIGH, 8'h03);
    reg_wr(sosc_pkg::ADDR_XMO_LOW, 8'hFF);
    reg_rd(sosc_pkg::ADDR_XMO_HIGH, 8'h00, "margin high");
    reg_rd(sosc_pkg::ADDR_XMO_LOW, 8'h00, "margin low");
    $display("test output fields done");
    cal_delay = 8'h14;
    reg_rd(sosc_pkg::ADDR_DEVICE_CONTROL, 8'h01, "device control");
    reg_wr(sosc_pkg::ADDR_DEVICE_CONTROL, 8'h03);
    reg_rd(sosc_pkg::ADDR_DEVICE_CONTROL, 8'h03, "trigger pending");
    check("outputs off", 8'h00, {7'h00, pll_ff.outputs_enable});
    wait_oe(1'b1, 100);
    reg_rd(sosc_pkg::ADDR_DEVICE_CONTROL, 8'h01, "trigger cleared");
    $display("test calibration trigger done");
    reg_wr(sosc_pkg::ADDR_DEVICE_CONTROL, 8'h41);
    repeat (3) @(negedge clk);
    check("synth enable", 8'h00, {7'h00, pll_ff.synth_enable});
    check("cal reset", 8'h01, {7'h00, pll_ff.cal_reset});
    check("outputs off", 8'h00, {7'h00, pll_ff.outputs_enable});
    reg_wr(sosc_pkg::ADDR_DEVICE_CONTROL, 8'h01);
    wait_oe(1'b1, 100);
    $display("test power down done");
    cal_delay = 8'h01;
    reg_wr(sosc_pkg::ADDR_SOFT_RESET, 8'h01);
    repeat (4) @(negedge clk);
    check("divider msb", 8'h00, {7'h00, msb_ff});
    check("driver mode", 8'h02, {6'h00, drv_mode_ff});
    reg_wr(sosc_pkg::ADDR_DEVICE_CONTROL, 8'h00);
    reg_wr(sosc_pkg::ADDR_DEVICE_CONTROL, 8'h02);
    repeat (30) @(negedge clk);
    check("halted", 8'h00, {7'h00, pll_ff.outputs_enable});
    reg_rd(sosc_pkg::ADDR_DEVICE_CONTROL, 8'h00, "halt control");
    reg_wr(sosc_pkg::ADDR_DEVICE_CONTROL, 8'h01);
    wait_oe(1'b1, 100);
    $display("test halt and software reset done");
    reg_wr(sosc_pkg::ADDR_DRV_CTL, 8'h03);
    @(negedge clk);
    pin_n = 1'b0;
    repeat (3) @(negedge clk);
    pin_n = 1'b1;
    repeat (2) @(negedge clk);
    reg_rd(sosc_pkg::ADDR_DRV_CTL, 8'h02, "driver control");
    wait_oe(1'b1, 100);
    $display("test reset pin done");
    reg_wr(sosc_pkg::ADDR_SOFT_RESET, 8'h01);
    repeat (4) @(negedge clk);
    reg_wr(sosc_pkg::ADDR_DEVICE_CONTROL, 8'h00);
    repeat (10) @(negedge clk);
    check("halted", 8'h00, {7'h00, pll_ff.outputs_enable});
    reg_wr(sosc_pkg::ADDR_DEVICE_CONTROL, 8'h02);
    wait_oe(1'b1, 100);
    reg_rd(sosc_pkg::ADDR_DEVICE_CONTROL, 8'h00, "halt trigger");
    $display("test trigger from halt done");
    print_verdict();
  end

  // Hang guard, far beyond the few hundred cycles the tests need
  initial
  begin
    #200000;
    bad_count++;
    print_verdict();
  end
endmodule : testbench
